// ---- core/video_sync_gen.sv ----
// Display sync generator with pixel front end and APB register slave
`timescale 1ns/100ps
`default_nettype none
module video_sync_gen #(
  parameter int                 DATA_W  = sync_gen_pkg::DATA_W_DEF,
  parameter int                 BEATS   = sync_gen_pkg::BEATS_DEF,
  parameter sync_gen_pkg::cnt_t H_SYNC  = sync_gen_pkg::H_SYNC_RST,
  parameter sync_gen_pkg::cnt_t H_BLANK = sync_gen_pkg::H_BLANK_RST,
  parameter sync_gen_pkg::cnt_t COLS    = sync_gen_pkg::COLS_RST,
  parameter sync_gen_pkg::cnt_t H_FRONT = sync_gen_pkg::H_FRONT_RST,
  parameter sync_gen_pkg::cnt_t V_SYNC  = sync_gen_pkg::V_SYNC_RST,
  parameter sync_gen_pkg::cnt_t V_BLANK = sync_gen_pkg::V_BLANK_RST,
  parameter sync_gen_pkg::cnt_t ROWS    = sync_gen_pkg::ROWS_RST,
  parameter sync_gen_pkg::cnt_t V_FRONT = sync_gen_pkg::V_FRONT_RST
) (
  input  wire logic                              clk_sys_i,
  input  wire logic                              reset_n_i,
  // APB slave
  input  wire logic [sync_gen_pkg::APB_AW-1:0]   paddr_i,
  input  wire logic                              psel_i,
  input  wire logic                              penable_i,
  input  wire logic                              pwrite_i,
  input  wire logic [sync_gen_pkg::APB_DW-1:0]   pwdata_i,
  input  wire logic [sync_gen_pkg::APB_DW/8-1:0] pstrb_i,
  output logic      [sync_gen_pkg::APB_DW-1:0]   prdata_o,
  output logic                                   pready_o,
  output logic                                   pslverr_o,
  // Pixel stream in (one extra symbol, dropped by the front end)
  input  wire logic [DATA_W+sync_gen_pkg::SYM_W-1:0] stream_data_i,
  input  wire logic                              stream_valid_i,
  input  wire logic                              stream_sop_i,
  input  wire logic                              stream_eop_i,
  input  wire logic                              stream_empty_i,
  output logic                                   stream_ready_o,
  // Display side
  output logic      [DATA_W-1:0]                 rgb_out_o,
  output logic                                   horizontal_sync_out_o,
  output logic                                   vertical_sync_out_o,
  output logic                                   display_enable_o
);
  import sync_gen_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int OUT_SYMBOLS = DATA_W / SYM_W;

  gen_state_t                state_reg;
  gen_state_t                state_next;
  logic                      en_reg;
  logic                      en_next;
  logic                      hpol_reg;
  logic                      hpol_next;
  logic                      vpol_reg;
  logic                      vpol_next;
  axis_cfg_t                 hcfg_reg;
  axis_cfg_t                 hcfg_next;
  axis_cfg_t                 vcfg_reg;
  axis_cfg_t                 vcfg_next;
  logic                      relock_reg;
  logic                      relock_next;
  logic                      eop_seen_reg;
  logic                      eop_seen_next;
  logic                      pready_reg;
  logic                      pready_next;
  logic                      pslverr_reg;
  logic                      pslverr_next;
  logic [APB_DW-1:0]         prdata_reg;
  logic [APB_DW-1:0]         prdata_next;
  logic                      ready_reg;
  logic                      ready_next;
  logic                      take_reg;
  logic                      take_next;
  logic                      first_d1_reg;
  logic                      first_d1_next;
  logic                      first_d2_reg;
  logic                      first_d2_next;
  logic                      hs_d1_reg;
  logic                      hs_d1_next;
  logic                      hs_d2_reg;
  logic                      hs_d2_next;
  logic                      vs_d1_reg;
  logic                      vs_d1_next;
  logic                      vs_d2_reg;
  logic                      vs_d2_next;
  logic [DATA_W-1:0]         rgb_reg;
  logic [DATA_W-1:0]         rgb_next;
  logic                      den_reg;
  logic                      den_next;
  logic                      hs_out_reg;
  logic                      hs_out_next;
  logic                      vs_out_reg;
  logic                      vs_out_next;

  logic [1:0]                beat_cnt;
  logic                      beat_wrap;
  cnt_t                      h_cnt;
  logic                      h_wrap;
  cnt_t                      v_cnt;
  logic [DATA_W-1:0]         fe_data;
  side_t                     fe_side_in;
  side_t                     fe_side;
  logic                      run;
  logic                      lock;
  logic                      step;
  logic                      h_act;
  logic                      v_act;
  logic                      first_pos;
  logic                      hs_raw;
  logic                      vs_raw;
  logic                      access;
  logic                      wr_fire;
  logic                      addr_hit;
  logic [APB_DW-1:0]         rd_mux;
  logic [APB_DW-1:0]         status_word;

  // Byte-lane merge of a write into a stored word
  function automatic logic [APB_DW-1:0] merge(input logic [APB_DW-1:0]   old_w,
                                              input logic [APB_DW-1:0]   new_w,
                                              input logic [APB_DW/8-1:0] strb);
    logic [APB_DW-1:0] res;
    res = old_w;
    for (int i = 0; i < APB_DW/8; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // Pixel front end
  // ----------------------------------------------------------------
  assign fe_side_in = '{sop: stream_sop_i, eop: stream_eop_i,
                        valid: stream_valid_i, empty: stream_empty_i};

  pixel_trim #(
    .SYM_W       (SYM_W),
    .OUT_SYMBOLS (OUT_SYMBOLS)
  ) u_trim (
    .data_in_i   (stream_data_i),
    .data_out_o  (fe_data),
    .side_in_i   (fe_side_in),
    .side_out_o  (fe_side),
    .ready_in_i  (ready_reg),
    .ready_out_o (stream_ready_o)
  );

  // ----------------------------------------------------------------
  // Position counters: beat within pixel, pixel within line, line
  // ----------------------------------------------------------------
  assign run  = (state_reg == ST_RUN);
  assign step = run && en_reg && !lock;

  span_counter #(.W(2)) u_beat (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .load_i     (lock),
    .load_val_i (2'h0),
    .step_i     (step),
    .last_i     (2'(BEATS - 1)),
    .count_o    (beat_cnt),
    .wrap_o     (beat_wrap)
  );

  span_counter #(.W(CNT_W)) u_pix (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .load_i     (lock),
    .load_val_i (cnt_t'(hcfg_reg.blank + cnt_t'(LOCK_AHEAD / BEATS))),
    .step_i     (beat_wrap),
    .last_i     (cnt_t'(hcfg_reg.blank + hcfg_reg.active + hcfg_reg.front - 1'b1)),
    .count_o    (h_cnt),
    .wrap_o     (h_wrap)
  );

  span_counter #(.W(CNT_W)) u_line (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .load_i     (lock),
    .load_val_i (vcfg_reg.blank),
    .step_i     (h_wrap),
    .last_i     (cnt_t'(vcfg_reg.blank + vcfg_reg.active + vcfg_reg.front - 1'b1)),
    .count_o    (v_cnt),
    .wrap_o     ()
  );

  // Decode of the current position
  always_comb begin
    h_act     = (h_cnt >= hcfg_reg.blank) &&
                (h_cnt < cnt_t'(hcfg_reg.blank + hcfg_reg.active));
    v_act     = (v_cnt >= vcfg_reg.blank) &&
                (v_cnt < cnt_t'(vcfg_reg.blank + vcfg_reg.active));
    first_pos = (v_cnt == vcfg_reg.blank) && (h_cnt == hcfg_reg.blank) && (beat_cnt == 2'h0);
    hs_raw    = (h_cnt < hcfg_reg.sync_w);
    vs_raw    = (v_cnt < vcfg_reg.sync_w);
  end

  // ----------------------------------------------------------------
  // Frame lock and pixel pipeline
  // ----------------------------------------------------------------
  // A start of frame taken while waiting, or off its expected slot, relocks
  assign lock = en_reg && take_reg && fe_side.sop && (!run || !first_d2_reg);

  always_comb begin
    state_next = state_reg;
    if (!en_reg) begin
      state_next = ST_WAIT;
    end else if (lock) begin
      state_next = ST_RUN;
    end
    case (state_reg)
      ST_WAIT: ready_next = en_reg;
      ST_RUN:  ready_next = en_reg && (lock || (h_act && v_act));
      default: ready_next = 1'b0;
    endcase
    if (lock) begin
      ready_next = 1'b1;
    end
    take_next     = ready_reg;
    first_d1_next = step && first_pos;
    first_d2_next = !lock && first_d1_reg;
    hs_d1_next    = step && hs_raw;
    hs_d2_next    = !lock && hs_d1_reg;
    vs_d1_next    = step && vs_raw;
    vs_d2_next    = !lock && vs_d1_reg;
    den_next      = take_reg && (run || lock);
    rgb_next      = den_next ? fe_data : '0;
    hs_out_next   = hpol_reg ? hs_d2_reg : !hs_d2_reg;
    vs_out_next   = vpol_reg ? vs_d2_reg : !vs_d2_reg;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg    <= ST_WAIT;
      ready_reg    <= 1'b0;
      take_reg     <= 1'b0;
      first_d1_reg <= 1'b0;
      first_d2_reg <= 1'b0;
      hs_d1_reg    <= 1'b0;
      hs_d2_reg    <= 1'b0;
      vs_d1_reg    <= 1'b0;
      vs_d2_reg    <= 1'b0;
      den_reg      <= 1'b0;
      rgb_reg      <= '0;
      hs_out_reg   <= !HPOL_RST;
      vs_out_reg   <= !VPOL_RST;
    end else begin
      state_reg    <= state_next;
      ready_reg    <= ready_next;
      take_reg     <= take_next;
      first_d1_reg <= first_d1_next;
      first_d2_reg <= first_d2_next;
      hs_d1_reg    <= hs_d1_next;
      hs_d2_reg    <= hs_d2_next;
      vs_d1_reg    <= vs_d1_next;
      vs_d2_reg    <= vs_d2_next;
      den_reg      <= den_next;
      rgb_reg      <= rgb_next;
      hs_out_reg   <= hs_out_next;
      vs_out_reg   <= vs_out_next;
    end
  end

  assign rgb_out_o             = rgb_reg;
  assign display_enable_o      = den_reg;
  assign horizontal_sync_out_o = hs_out_reg;
  assign vertical_sync_out_o   = vs_out_reg;

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------
  assign access  = psel_i && penable_i && !pready_reg;
  assign wr_fire = psel_i && penable_i && pready_reg && pwrite_i;

  assign status_word = {v_cnt, 13'h0000, eop_seen_reg, relock_reg, run};

  // Read decode
  always_comb begin
    addr_hit = 1'b1;
    case (paddr_i)
      CTRL_OFS:   rd_mux = {29'h00000000, vpol_reg, hpol_reg, en_reg};
      HTIME0_OFS: rd_mux = {hcfg_reg.blank, hcfg_reg.sync_w};
      HTIME1_OFS: rd_mux = {hcfg_reg.front, hcfg_reg.active};
      VTIME0_OFS: rd_mux = {vcfg_reg.blank, vcfg_reg.sync_w};
      VTIME1_OFS: rd_mux = {vcfg_reg.front, vcfg_reg.active};
      STATUS_OFS: rd_mux = status_word;
      default: begin
        rd_mux   = '0;
        addr_hit = 1'b0;
      end
    endcase
  end

  // Register writes and sticky status; a new event beats a clear
  always_comb begin
    logic [APB_DW-1:0] w;
    w             = '0;
    pready_next   = access;
    pslverr_next  = access && !addr_hit;
    prdata_next   = (access && !pwrite_i) ? rd_mux : '0;
    en_next       = en_reg;
    hpol_next     = hpol_reg;
    vpol_next     = vpol_reg;
    hcfg_next     = hcfg_reg;
    vcfg_next     = vcfg_reg;
    relock_next   = relock_reg;
    eop_seen_next = eop_seen_reg;
    if (wr_fire) begin
      w = merge(rd_mux, pwdata_i, pstrb_i);
      case (paddr_i)
        CTRL_OFS: begin
          en_next   = w[CTRL_EN_BIT];
          hpol_next = w[CTRL_HPOL_BIT];
          vpol_next = w[CTRL_VPOL_BIT];
        end
        HTIME0_OFS: begin
          hcfg_next.sync_w = w[LO_LSB +: CNT_W];
          hcfg_next.blank  = w[HI_LSB +: CNT_W];
        end
        HTIME1_OFS: begin
          hcfg_next.active = w[LO_LSB +: CNT_W];
          hcfg_next.front  = w[HI_LSB +: CNT_W];
        end
        VTIME0_OFS: begin
          vcfg_next.sync_w = w[LO_LSB +: CNT_W];
          vcfg_next.blank  = w[HI_LSB +: CNT_W];
        end
        VTIME1_OFS: begin
          vcfg_next.active = w[LO_LSB +: CNT_W];
          vcfg_next.front  = w[HI_LSB +: CNT_W];
        end
        STATUS_OFS: begin
          relock_next   = relock_reg && !(pstrb_i[0] && pwdata_i[STAT_RELCK_BIT]);
          eop_seen_next = eop_seen_reg && !(pstrb_i[0] && pwdata_i[STAT_EOP_BIT]);
        end
        default: ;
      endcase
    end
    if (lock && run) begin
      relock_next = 1'b1;
    end
    if (take_reg && run && fe_side.eop) begin
      eop_seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= '0;
      en_reg       <= EN_RST;
      hpol_reg     <= HPOL_RST;
      vpol_reg     <= VPOL_RST;
      hcfg_reg     <= '{sync_w: H_SYNC, blank: H_BLANK, active: COLS, front: H_FRONT};
      vcfg_reg     <= '{sync_w: V_SYNC, blank: V_BLANK, active: ROWS, front: V_FRONT};
      relock_reg   <= 1'b0;
      eop_seen_reg <= 1'b0;
    end else begin
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      prdata_reg   <= prdata_next;
      en_reg       <= en_next;
      hpol_reg     <= hpol_next;
      vpol_reg     <= vpol_next;
      hcfg_reg     <= hcfg_next;
      vcfg_reg     <= vcfg_next;
      relock_reg   <= relock_next;
      eop_seen_reg <= eop_seen_next;
    end
  end

  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign prdata_o  = prdata_reg;

endmodule : video_sync_gen
`default_nettype wire

// ---- include/sync_gen_pkg.sv ----
// Shared constants and types for the display sync generator and its pixel front end
package sync_gen_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W      = 16;
  localparam int APB_AW     = 8;
  localparam int APB_DW     = 32;
  localparam int SYM_W      = 8;
  localparam int DATA_W_DEF = 24;
  localparam int BEATS_DEF  = 1;
  // Beats already requested by the time a start of frame is seen
  localparam int LOCK_AHEAD = 3;

  typedef logic [CNT_W-1:0] cnt_t;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [APB_AW-1:0] HTIME0_OFS = 8'h04;
  localparam logic [APB_AW-1:0] HTIME1_OFS = 8'h08;
  localparam logic [APB_AW-1:0] VTIME0_OFS = 8'h0c;
  localparam logic [APB_AW-1:0] VTIME1_OFS = 8'h10;
  localparam logic [APB_AW-1:0] STATUS_OFS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_HPOL_BIT  = 1;
  localparam int CTRL_VPOL_BIT  = 2;
  localparam int LO_LSB         = 0;
  localparam int HI_LSB         = 16;
  localparam int STAT_LOCK_BIT  = 0;
  localparam int STAT_RELCK_BIT = 1;
  localparam int STAT_EOP_BIT   = 2;
  localparam int STAT_LINE_LSB  = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic EN_RST   = 1'h1;
  localparam logic HPOL_RST = 1'h0;
  localparam logic VPOL_RST = 1'h0;
  localparam cnt_t H_SYNC_RST  = 16'h001e;
  localparam cnt_t H_BLANK_RST = 16'h002e;
  localparam cnt_t COLS_RST    = 16'h0320;
  localparam cnt_t H_FRONT_RST = 16'h00d2;
  localparam cnt_t V_SYNC_RST  = 16'h0003;
  localparam cnt_t V_BLANK_RST = 16'h0017;
  localparam cnt_t ROWS_RST    = 16'h01e0;
  localparam cnt_t V_FRONT_RST = 16'h0016;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // One axis of timing, in pixels (horizontal) or lines (vertical)
  typedef struct packed {
    cnt_t sync_w;
    cnt_t blank;
    cnt_t active;
    cnt_t front;
  } axis_cfg_t;

  // Stream sideband that travels beside the pixel data
  typedef struct packed {
    logic sop;
    logic eop;
    logic valid;
    logic empty;
  } side_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } gen_state_t;

endpackage : sync_gen_pkg

// ---- core/span_counter.sv ----
// Wrapping position counter with load, used for beat, pixel and line position
`timescale 1ns/100ps
`default_nettype none
module span_counter #(
  parameter int W = 16
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         step_i,
  input  wire logic [W-1:0] last_i,
  output logic      [W-1:0] count_o,
  output logic              wrap_o
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Wrap also when a shrunk limit leaves the count beyond it
  assign wrap_o  = step_i && (count_reg >= last_i);
  assign count_o = count_reg;

  // Next count
  always_comb begin
    count_next = count_reg;
    if (load_i) begin
      count_next = load_val_i;
    end else if (step_i) begin
      count_next = wrap_o ? '0 : count_reg + 1'b1;
    end
  end

  // Count register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : span_counter
`default_nettype wire

// ---- core/pixel_trim.sv ----
// Pixel front end: drops the lowest symbol of each input beat, sideband wired through
`timescale 1ns/100ps
`default_nettype none
module pixel_trim #(
  parameter int SYM_W       = 8,
  parameter int OUT_SYMBOLS = 3
) (
  input  wire logic [(OUT_SYMBOLS+1)*SYM_W-1:0] data_in_i,
  output logic      [OUT_SYMBOLS*SYM_W-1:0]     data_out_o,
  input  wire sync_gen_pkg::side_t               side_in_i,
  output sync_gen_pkg::side_t                    side_out_o,
  input  wire logic                              ready_in_i,
  output logic                                   ready_out_o
);
  import sync_gen_pkg::*;

  // Upper symbols pass straight through, lowest one is dropped
  assign data_out_o = data_in_i[(OUT_SYMBOLS+1)*SYM_W-1:SYM_W];

  // Sideband and ready cross without any register
  assign side_out_o  = side_in_i;
  assign ready_out_o = ready_in_i;

endmodule : pixel_trim
`default_nettype wire

// ---- verif/sync_gen_asserts.sv ----
// Concurrent checks on the sync generator's stream and display ports
`timescale 1ns/100ps
`default_nettype none
module sync_gen_asserts #(
  parameter int DATA_W = 24
) (
  input wire logic                                  clk_sys_i,
  input wire logic                                  reset_n_i,
  input wire logic [DATA_W+sync_gen_pkg::SYM_W-1:0] stream_data_i,
  input wire logic                                  stream_ready_o,
  input wire logic [DATA_W-1:0]                     rgb_out_o,
  input wire logic                                  horizontal_sync_out_o,
  input wire logic                                  vertical_sync_out_o,
  input wire logic                                  display_enable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------------------------------
  // Pixel path; gaps of 8 match the bench's front porch plus blank
  // ----------------------------------------------------------------
  den_zero_rgb_a: assert property (!display_enable_o |-> rgb_out_o == '0)
    else $error("display data not zero while enable low");
  den_after_ready_a: assert property (display_enable_o |-> $past(stream_ready_o, 2))
    else $error("display enable without a requested beat");
  rgb_pass_a: assert property (display_enable_o |-> rgb_out_o == $past(stream_data_i[DATA_W+7:8]))
    else $error("displayed pixel differs from trimmed beat");
  ready_gap_a: assert property ($fell(stream_ready_o) |-> !stream_ready_o [*8])
    else $error("ready raised inside horizontal blanking");
  den_run_a: assert property ($rose(display_enable_o) |-> display_enable_o [*8])
    else $error("active columns cut short");
  den_gap_a: assert property ($fell(display_enable_o) |-> !display_enable_o [*8])
    else $error("display enable inside blanking");
  // ----------------------------------------------------------------
  // Sync relations
  // ----------------------------------------------------------------
  vsync_line_a: assert property ($changed(vertical_sync_out_o) |-> $changed(horizontal_sync_out_o))
    else $error("vertical sync moved off a line start");
  hsync_quiet_a: assert property (display_enable_o |-> $stable(horizontal_sync_out_o))
    else $error("horizontal sync moved in active columns");
endmodule : sync_gen_asserts
bind video_sync_gen sync_gen_asserts #(.DATA_W(DATA_W)) sync_gen_asserts_i (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .stream_data_i(stream_data_i),
  .stream_ready_o(stream_ready_o), .rgb_out_o(rgb_out_o),
  .horizontal_sync_out_o(horizontal_sync_out_o), .vertical_sync_out_o(vertical_sync_out_o),
  .display_enable_o(display_enable_o));
`default_nettype wire

// ---- verif/pixel_source.sv ----
// Streaming pixel source model that answers every ready cycle with a beat
`timescale 1ns/100ps
`default_nettype none
module pixel_source #(
  parameter int W     = 32,
  parameter int FRAME = 24
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic         ready_i,
  output logic      [W-1:0] data_o,
  output logic              sop_o,
  output logic              eop_o,
  output logic              valid_o,
  output logic              empty_o
);
  int idx;
  assign empty_o = 1'b0;
  // Beat follows each ready cycle; idle bus keeps changing
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx <= 0;
      data_o <= '0;
      sop_o <= 1'b0;
      eop_o <= 1'b0;
      valid_o <= 1'b0;
    end else if (ready_i) begin
      data_o <= W'($urandom());
      sop_o <= (idx == 0);
      eop_o <= (idx == FRAME - 1);
      valid_o <= 1'b1;
      idx <= (idx + 1) % FRAME;
    end else begin
      data_o <= ~data_o;
      sop_o <= 1'b0;
      eop_o <= 1'b0;
      valid_o <= 1'b0;
    end
  end
endmodule : pixel_source
`default_nettype wire

// ---- verif/video_sync_gen_tb.sv ----
// Self-checking bench for the sync generator with a queue model of the pixel path
`timescale 1ns/100ps
`default_nettype none
module video_sync_gen_tb;
  import sync_gen_pkg::*;
  localparam int LINE = 16;
  logic        clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i;
  logic [3:0]  pstrb_i;
  logic [31:0] pwdata_i, prdata_o, stream_data_i, rd;
  logic        stream_valid_i, stream_sop_i, stream_eop_i, stream_empty_i, stream_ready_o;
  logic [23:0] rgb_out_o;
  logic        horizontal_sync_out_o, vertical_sync_out_o, display_enable_o, err, locked, r1;
  logic [23:0] q[$];
  int          num_errors, checks, cyc;

  video_sync_gen #(.H_SYNC(16'h0002), .H_BLANK(16'h0004), .COLS(16'h0008),
    .H_FRONT(16'h0004), .ROWS(16'h0003)) video_sync_gen_i (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .stream_data_i(stream_data_i), .stream_valid_i(stream_valid_i),
    .stream_sop_i(stream_sop_i), .stream_eop_i(stream_eop_i),
    .stream_empty_i(stream_empty_i), .stream_ready_o(stream_ready_o),
    .rgb_out_o(rgb_out_o), .horizontal_sync_out_o(horizontal_sync_out_o),
    .vertical_sync_out_o(vertical_sync_out_o), .display_enable_o(display_enable_o));
  pixel_source pixel_source_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .ready_i(stream_ready_o), .data_o(stream_data_i), .sop_o(stream_sop_i),
    .eop_o(stream_eop_i), .valid_o(stream_valid_i), .empty_o(stream_empty_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // APB transfer; waits for pready, then releases
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb

  function automatic logic sig(input int v);
    return v ? vertical_sync_out_o : horizontal_sync_out_o;
  endfunction : sig

  // Length of the next full run of one sync at the given level
  task automatic width(input int v, input logic act, input int exp);
    int n = 0;
    while (sig(v) === act) @(posedge clk_sys_i);
    while (sig(v) !== act) @(posedge clk_sys_i);
    while (sig(v) === act) begin
      @(posedge clk_sys_i);
      n++;
    end
    check("sync run", n, exp);
  endtask : width

  // Model: beats taken after ready, dropped until sop, shown in order
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 6000) begin
      num_errors++;
      report_and_stop();
    end
    r1 <= stream_ready_o;
    if (r1 && (locked || stream_sop_i === 1'b1)) begin
      locked = 1'b1;
      q.push_back(stream_data_i[31:8]);
    end
    if (display_enable_o === 1'b1) check("rgb", rgb_out_o, q.size() ? q.pop_front() : 'x);
  end

  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pstrb_i = 4'hf;
    {reset_n_i, locked, r1} = '0;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(84689));
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl", rd, 32'h1);
    apb(1'b0, HTIME0_OFS, 32'h0);
    check("htime0", rd, 32'h0004_0002);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    // Only the upper lanes may land; the random lower half must be ignored
    pstrb_i <= 4'hc;
    apb(1'b1, HTIME0_OFS, {16'h0004, 16'($urandom())});
    pstrb_i <= 4'hf;
    apb(1'b0, HTIME0_OFS, 32'h0);
    check("strobe", rd, 32'h0004_0002);
    repeat (250) @(posedge clk_sys_i);
    width(0, 1'b0, 2);
    width(0, 1'b1, LINE - 2);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("lock", rd[0], 32'h1);
    check("eop", rd[2], 32'h1);
    width(1, 1'b0, V_SYNC_RST * LINE);
    apb(1'b1, CTRL_OFS, 32'h0);
    // Let a beat in flight reach the display before the model forgets it
    repeat (20) @(posedge clk_sys_i);
    locked = 1'b0;
    q.delete();
    check("ready off", stream_ready_o, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("unlocked", rd[0], 32'h0);
    apb(1'b1, CTRL_OFS, 32'h7);
    repeat (250) @(posedge clk_sys_i);
    width(0, 1'b1, 2);
    width(1, 1'b1, V_SYNC_RST * LINE);
    report_and_stop();
  end
endmodule : video_sync_gen_tb
`default_nettype wire
